// >>> logic/window_watchdog_timer.sv
// Window watchdog timer with an AHB-Lite register slave.
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "windowed_watchdog_map.svh"

module window_watchdog_timer #(
  parameter int PRESC_DIV = `WD_PRESC_DIV,
  parameter int PULSE_CYC = `WD_RST_PULSE_CYC
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire windowed_watchdog_pkg::htrans_t i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic i_hready,
  input wire logic [31:0] i_hwdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Option settings and core power state.
  input wire logic i_hw_activate,
  input wire logic i_halt_reset_opt,
  input wire logic i_wake_long,
  input wire logic i_halt_exec,
  input wire logic i_wake_irq,
  // Device reset pin and state.
  output logic o_rst_n,
  output logic o_active
);
  import windowed_watchdog_pkg::*;

  localparam int PW = PULSE_CYC;

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [13:0] presc_q;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] win_q;
  logic act_q;
  logic wr_q;
  logic [`WD_ADDR_W-1:0] addr_q;
  logic [9:0] pulse_q;
  logic [12:0] wake_q;
  wd_state_t st_q;
  wd_state_t st_d;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  // An address phase is taken only when the bus is ready; zero wait states.
  wire addr_ph = i_hsel & i_hready & i_htrans[1];
  wire [`WD_ADDR_W-1:0] a_ofs = i_haddr[`WD_ADDR_W-1:0];
  wire wr_ctl = wr_q & (addr_q == `WD_OFS_CTRL);
  wire wr_win = wr_q & (addr_q == `WD_OFS_WIN);
  wire [6:0] wdata_cnt = i_hwdata[6:0];
  wire wdata_act = i_hwdata[`WD_ACT_BIT];
  wire wdata_top = i_hwdata[`WD_TOP_BIT];

  // Hardware activation forces the watchdog active; the control register still reads back the activate bit alone.
  wire active = act_q | i_hw_activate;
  wire busy = (pulse_q != 10'h000);
  wire tick = (presc_q == 14'h0000);
  wire run = (st_q == ST_RUN) | (st_q == ST_HALT_STEP);

  // Reset causes. A write in progress replaces the decrement, so the
  // rollover test only looks at cycles without a control write.
  wire roll = active & run & tick & ~wr_ctl & (cnt_q == `WD_ROLL_VAL);
  wire win_bad = wr_ctl & active & (cnt_q > win_q);
  wire sw_rst = wr_ctl & wdata_act & ~wdata_top;
  wire halt_rst = i_halt_exec & active & i_halt_reset_opt & (st_q == ST_RUN);
  wire fire = ~busy & (roll | win_bad | sw_rst | halt_rst);

  // ---------------------------------------------------------------------------
  // Read data mux
  // ---------------------------------------------------------------------------
  wire [31:0] rd_ctl = {24'h000000, act_q, cnt_q};
  wire [31:0] rd_win = {25'h0000000, win_q};
  wire [31:0] rd_stat = {29'h00000000, st_q == ST_HALTED, busy, active};
  wire [31:0] rd_mux = (a_ofs == `WD_OFS_CTRL) ? rd_ctl :
                       (a_ofs == `WD_OFS_WIN) ? rd_win :
                       (a_ofs == `WD_OFS_STAT) ? rd_stat : 32'h00000000;
  // Read data is captured in the address phase so that it stands in the data phase.
  wire [31:0] rd_next = (addr_ph & ~i_hwrite) ? rd_mux : 32'h00000000;

  // ---------------------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------------------
  // A write is remembered for its data phase, where the write data stands.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= addr_ph & i_hwrite;
      addr_q <= a_ofs;
    end
  end

  // ---------------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------------
  // Free running; a control write does not touch it, so the timeout has an
  // uncertainty of one prescaler period.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      presc_q <= 14'h0000;
    end else if (tick) begin
      presc_q <= 14'(PRESC_DIV - 1);
    end else begin
      presc_q <= presc_q - 14'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Downcounter
  // ---------------------------------------------------------------------------
  // Wraps through zero and runs whether or not the watchdog is active; the
  // low six bits give the step count before the top bit drops. Wait mode has
  // no input here because it changes nothing.
  always_comb begin
    cnt_d = cnt_q;
    if (wr_ctl) begin
      cnt_d = wdata_cnt;
    end else if (tick & run) begin
      cnt_d = cnt_q - `WD_CNT_ONE;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= `WD_CNT_RST;
      win_q <= `WD_WIN_RST;
      act_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (wr_win) begin
        win_q <= wdata_cnt;
      end
      if (wr_ctl & wdata_act) begin
        act_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Halt handling
  // ---------------------------------------------------------------------------
  // Without the reset option, halt lets one more decrement through and then
  // freezes the counter until a waking interrupt plus a settling delay.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RUN: begin
        if (i_halt_exec & ~halt_rst) begin
          st_d = ST_HALT_STEP;
        end
      end
      ST_HALT_STEP: begin
        if (i_wake_irq) begin
          st_d = ST_RUN;
        end else if (tick) begin
          st_d = ST_HALTED;
        end
      end
      ST_HALTED: begin
        if (i_wake_irq) begin
          st_d = ST_RESUME;
        end
      end
      ST_RESUME: begin
        if (wake_q == 13'h0000) begin
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_RUN;
      wake_q <= 13'h0000;
    end else begin
      st_q <= st_d;
      if (st_q == ST_HALTED) begin
        wake_q <= i_wake_long ? 13'(`WD_WAKE_LONG - 1) : 13'(`WD_WAKE_SHORT - 1);
      end else if (wake_q != 13'h0000) begin
        wake_q <= wake_q - 13'h0001;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Reset pulse
  // ---------------------------------------------------------------------------
  // Further causes during a pulse are ignored; the device reset that the pulse
  // produces clears the whole block anyway.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_q <= 10'h000;
      o_rst_n <= 1'b1;
    end else begin
      if (fire) begin
        pulse_q <= 10'(PULSE_CYC);
      end else if (busy) begin
        pulse_q <= pulse_q - 10'h001;
      end
      o_rst_n <= ~(fire | (pulse_q > 10'h001));
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= 32'h00000000;
      o_active <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= rd_next;
      o_active <= active;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  AST_PRESC_STEP: assert property (!tick && !$past(i_rst) |=> presc_q == $past(presc_q) - 14'h0001)
    else $error("Prescaler did not step down by one.");
  AST_PRESC_KEEP: assert property (wr_ctl && !tick |=> presc_q != 14'(PRESC_DIV - 1))
    else $error("Control write reloaded the prescaler.");
  AST_ROLL_RST: assert property (roll && !busy |=> !o_rst_n)
    else $error("Rollover did not pull the reset pin.");
  AST_PULSE_LEN: assert property ($fell(o_rst_n) |-> ##[PW:PW] $rose(o_rst_n))
    else $error("Reset pulse length wrong.");
  AST_WIN_RST: assert property (wr_ctl && active && cnt_q > win_q && !busy |=> !o_rst_n)
    else $error("Early refresh did not reset.");
  AST_WIN_OK: assert property (wr_ctl && !busy && !(active && cnt_q > win_q) && !sw_rst && !halt_rst
                               && !(roll) |=> o_rst_n)
    else $error("Refresh inside window caused a reset.");
  AST_ACT_STICK: assert property (act_q |=> act_q)
    else $error("Activate bit cleared without reset.");
  AST_HW_ACT: assert property (i_hw_activate |=> o_active)
    else $error("Hardware activation not active.");
  AST_FREE_RUN: assert property (tick && run && !wr_ctl |=> cnt_q == $past(cnt_q) - `WD_CNT_ONE)
    else $error("Counter did not decrement.");
  AST_SW_RST: assert property (sw_rst && !busy |=> !o_rst_n)
    else $error("Software reset not produced.");
  AST_HALT_RST: assert property (halt_rst && !busy |=> !o_rst_n)
    else $error("Halt did not reset.");
  AST_HALT_FREEZE: assert property (st_q == ST_HALTED && !wr_ctl |=> cnt_q == $past(cnt_q))
    else $error("Counter moved during halt.");
  AST_LOAD: assert property (wr_ctl |=> cnt_q == $past(wdata_cnt))
    else $error("Control write did not load the counter.");
  AST_QUIET_OFF: assert property (!active && !wr_ctl && !busy |=> o_rst_n)
    else $error("Inactive watchdog pulled the reset pin.");
  AST_RD_DATA: assert property (addr_ph && !i_hwrite && a_ofs == `WD_OFS_CTRL |=> o_hrdata == {24'h000000, $past(act_q), $past(cnt_q)})
    else $error("Control read returned wrong data.");
  AST_RESUME_HOLD: assert property (st_q == ST_RESUME && !wr_ctl |=> cnt_q == $past(cnt_q))
    else $error("Counter moved during the wake delay.");
  AST_BUS_OKAY: assert property (o_hreadyout && !o_hresp)
    else $error("Bus slave stalled or answered with an error.");

  COV_ROLL: cover property (roll ##1 !o_rst_n);
  COV_WIN: cover property (win_bad ##1 !o_rst_n);
  COV_HALT: cover property (st_q == ST_HALTED ##[1:300] st_q == ST_RUN);
  COV_REFRESH: cover property (wr_ctl && active && !win_bad && !sw_rst);
  COV_SW: cover property (sw_rst ##1 !o_rst_n);
endmodule

// >>> logic/windowed_watchdog_map.svh
// Register offsets, field positions, reset values and timing figures of the window watchdog.
`ifndef WINDOWED_WATCHDOG_MAP_SVH
`define WINDOWED_WATCHDOG_MAP_SVH
// -----------------------------------------------------------------------------
// Register map
// -----------------------------------------------------------------------------
`define WD_ADDR_W 8
`define WD_OFS_CTRL 8'h00
`define WD_OFS_WIN 8'h04
`define WD_OFS_STAT 8'h08
// -----------------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------------
`define WD_ACT_BIT 7
`define WD_TOP_BIT 6
`define WD_CNT_RST 7'h7F
`define WD_WIN_RST 7'h7F
`define WD_ROLL_VAL 7'h40
`define WD_CNT_ONE 7'h01
`define WD_STAT_ACT 0
`define WD_STAT_BUSY 1
`define WD_STAT_HALT 2
// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define WD_PRESC_DIV 16384
`define WD_CLK_PERIOD_NS 50
`define WD_RST_PULSE_NS 30000
`define WD_RST_PULSE_CYC (`WD_RST_PULSE_NS / `WD_CLK_PERIOD_NS)
`define WD_WAKE_SHORT 256
`define WD_WAKE_LONG 4096
`endif

// >>> logic/windowed_watchdog_pkg.sv
// Types shared by the window watchdog.
package windowed_watchdog_pkg;
  typedef logic [1:0] htrans_t;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HALT_STEP = 4'h2,
    ST_HALTED = 4'h4,
    ST_RESUME = 4'h8
  } wd_state_t;
endpackage

// >>> dv/window_watchdog_timer_tb.sv
// Self-checking testbench of the window watchdog timer.
`timescale 1ns/1ps
`include "windowed_watchdog_map.svh"
module window_watchdog_timer_tb;
  import windowed_watchdog_pkg::*;
  // A short prescaler keeps the run brief; every expected counter time is derived from it, the pulse and wake times from the map.
  localparam int DIV = 16;
  localparam int PULSE = `WD_RST_PULSE_CYC;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic i_hsel = 1'h0;
  logic [31:0] i_haddr = 32'h0;
  htrans_t i_htrans = 2'h0;
  logic i_hwrite = 1'h0;
  logic [2:0] i_hsize = 3'h2;
  logic i_hready;
  logic [31:0] i_hwdata = 32'h0;
  logic o_hreadyout;
  logic o_hresp;
  logic [31:0] o_hrdata;
  logic i_hw_activate = 1'h0;
  logic i_halt_reset_opt = 1'h0;
  logic i_wake_long = 1'h0;
  logic i_halt_exec = 1'h0;
  logic i_wake_irq = 1'h0;
  logic o_rst_n;
  logic o_active;
  int fails = 0;
  int n_compared = 0;
  int n;
  logic [31:0] r0;
  logic [31:0] r1;

  // The single slave's ready is the bus ready.
  assign i_hready = o_hreadyout;

  always #25 i_clk = ~i_clk;

  window_watchdog_timer #(.PRESC_DIV(DIV), .PULSE_CYC(PULSE)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hready(i_hready), .i_hwdata(i_hwdata),
    .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_hrdata(o_hrdata),
    .i_hw_activate(i_hw_activate), .i_halt_reset_opt(i_halt_reset_opt), .i_wake_long(i_wake_long),
    .i_halt_exec(i_halt_exec), .i_wake_irq(i_wake_irq), .o_rst_n(o_rst_n), .o_active(o_active));

  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Advances to the next edge with ready high; a stuck bus ends the run.
  task automatic edge_ready;
    int k;
    k = 0;
    @(posedge i_clk);
    while (i_hready !== 1'h1) begin
      k++;
      if (k > 50) begin
        fails++;
        summarize;
      end
      @(posedge i_clk);
    end
  endtask

  // One single transfer: address phase, then data phase; read data taken at the closing edge.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk);
    i_hsel <= 1'h1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    edge_ready;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    edge_ready;
    r = o_hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(a, 1'h1, d, t);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(a, 1'h0, 32'h0, r);
  endtask

  // Counts edges until the reset pin shows v; running out of the bound ends the run.
  task automatic pin_wait(input logic v, input int lim, output int c);
    c = 0;
    @(posedge i_clk);
    #1;
    while (o_rst_n !== v && c < lim) begin
      @(posedge i_clk);
      #1;
      c++;
    end
    if (o_rst_n !== v) begin
      fails++;
      summarize;
    end
  endtask

  task automatic rst_all;
    @(posedge i_clk);
    i_rst <= 1'h1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'h0;
  endtask

  task automatic pulse_halt;
    @(posedge i_clk);
    i_halt_exec <= 1'h1;
    @(posedge i_clk);
    i_halt_exec <= 1'h0;
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    rst_all;
    rd(`WD_OFS_WIN, r0);
    chk("window reset", {25'h0, `WD_WIN_RST}, r0);
    rd(`WD_OFS_STAT, r0);
    chk("status reset", 32'h0, r0);
    rd(8'h0C, r0);
    chk("unmapped", 32'h0, r0);
    chk("hresp", 32'h0, {31'h0, o_hresp});
    chk("hready", 32'h1, {31'h0, o_hreadyout});
    // Two reads 64 edges apart see exactly 64/DIV steps, whatever the prescaler phase.
    rd(`WD_OFS_CTRL, r0);
    repeat (61) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r1);
    chk("step", r0 - 64 / DIV, r1);
    repeat (64 * DIV + 100) @(posedge i_clk);
    #1;
    chk("pin while disabled", 32'h1, {31'h0, o_rst_n});
    // Activate with the top bit clear: immediate reset, pulse of fixed width.
    rst_all;
    wr(`WD_OFS_CTRL, 32'hBF);
    pin_wait(1'h0, 3, n);
    pin_wait(1'h1, 1000, n);
    // The first low edge and the first edge of the second wait are not counted.
    chk("pulse width", PULSE - 2, n);
    // Activation sticks after a write with the bit clear; rollover then resets.
    rst_all;
    wr(`WD_OFS_CTRL, 32'hC2);
    wr(`WD_OFS_CTRL, 32'h42);
    rd(`WD_OFS_STAT, r0);
    chk("still active", 32'h1, r0 & 32'h1);
    chk("active pin", 32'h1, {31'h0, o_active});
    pin_wait(1'h0, 4 * DIV + 8, n);
    chk("not early", 32'h1, {31'h0, n > DIV});
    // Refresh inside the window passes, refresh above the limit resets.
    rst_all;
    wr(`WD_OFS_WIN, 32'h50);
    wr(`WD_OFS_CTRL, 32'hC8);
    wr(`WD_OFS_CTRL, 32'hFF);
    repeat (3) @(posedge i_clk);
    #1;
    chk("refresh in window", 32'h1, {31'h0, o_rst_n});
    wr(`WD_OFS_CTRL, 32'hFF);
    pin_wait(1'h0, 3, n);
    // Hardware activation: active without the bit, rollover from reset value resets.
    @(posedge i_clk);
    i_hw_activate <= 1'h1;
    rst_all;
    repeat (2) @(posedge i_clk);
    #1;
    chk("hw active", 32'h1, {31'h0, o_active});
    pin_wait(1'h0, 64 * DIV + 8, n);
    chk("hw timeout", 32'h1, {31'h0, n >= 62 * DIV});
    // Halt with the reset option while active.
    rst_all;
    i_halt_reset_opt <= 1'h1;
    pulse_halt;
    pin_wait(1'h0, 3, n);
    // Halt without reset: counting freezes, then resumes after the short wake delay.
    @(posedge i_clk);
    i_hw_activate <= 1'h0;
    i_halt_reset_opt <= 1'h0;
    rst_all;
    wr(`WD_OFS_CTRL, 32'h7F);
    pulse_halt;
    repeat (3 * DIV) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r0);
    repeat (4 * DIV) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r1);
    chk("frozen", r0, r1);
    rd(`WD_OFS_STAT, r1);
    chk("halted status", 32'h4, r1);
    @(posedge i_clk);
    i_wake_irq <= 1'h1;
    @(posedge i_clk);
    i_wake_irq <= 1'h0;
    repeat (`WD_WAKE_SHORT + 2 * DIV) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r1);
    chk("resumed", 32'h1, {31'h0, r1 < r0});
    // Long wake delay: still frozen after the short delay, counting after the long one.
    wr(`WD_OFS_CTRL, 32'h7F);
    i_wake_long <= 1'h1;
    pulse_halt;
    repeat (3 * DIV) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r0);
    @(posedge i_clk);
    i_wake_irq <= 1'h1;
    @(posedge i_clk);
    i_wake_irq <= 1'h0;
    repeat (`WD_WAKE_SHORT + 2 * DIV) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r1);
    chk("long wake frozen", r0, r1);
    repeat (`WD_WAKE_LONG) @(posedge i_clk);
    rd(`WD_OFS_CTRL, r1);
    chk("long wake resumed", 32'h1, {31'h0, r1 < r0});
    summarize;
  end
endmodule
